// File: dv/rcw_monitor.sv
`timescale 1ns/10ps
module rcw_monitor
	import rcw_pkg::*;
#(
	parameter int unsigned OSC_DIVIDE = OSC_DIV
)(
	// Clock, reset and bus
	input logic              clk, arst_n, psel, penable, pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0]       prdata,
	// Events and reset outputs
	input logic [7:0]        reset_vector_low,
	input logic              stop_exec, internal_reset, break_state, rst_test_high_voltage,
	input logic              system_reset, illegal_op_reset, rst_pin_out, rst_pin_oe
);
	logic [15:0] wid_q;
	logic [15:0] wid_d;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Pin pulse width in clocks
	always_comb wid_d = rst_pin_oe ? wid_q + 16'h1 : 16'h0;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) wid_q <= 16'h0;
		else wid_q <= wid_d;
	sequence svc_setup;
		psel && !penable && !pwrite && paddr == 18'h3fffc;
	endsequence
	sequence svc_access;
		psel && penable;
	endsequence
	pulse_once_a: assert property (system_reset |=> !system_reset)
		else $error("system reset longer than one cycle");
	pin_start_a: assert property ($rose(system_reset) |-> rst_pin_oe && !$past(rst_pin_oe))
		else $error("reset pin not started with system reset");
	pin_low_a: assert property (rst_pin_oe |-> !rst_pin_out)
		else $error("reset pin driven high");
	pin_width_a: assert property ($fell(rst_pin_oe) |-> wid_q >= 31*OSC_DIVIDE && wid_q <= 32*OSC_DIVIDE+1)
		else $error("reset pin pulse width wrong");
	brk_block_a: assert property ((break_state && rst_test_high_voltage)[*3] |-> !system_reset)
		else $error("reset during break with test voltage");
	intrst_block_a: assert property (internal_reset[*3] |-> !system_reset)
		else $error("reset while internal reset held");
	illop_cause_a: assert property ($rose(illegal_op_reset) |-> $past(stop_exec))
		else $error("illegal op reset without stop");
	svc_read_a: assert property (svc_setup ##1 svc_access |-> prdata == {24'h0, $past(reset_vector_low)})
		else $error("service read data wrong");
endmodule // rcw_monitor

bind rcw_top rcw_monitor #(.OSC_DIVIDE(OSC_DIVIDE)) i_rcw_monitor (.clk, .arst_n, .psel, .penable,
	.pwrite, .paddr, .prdata, .reset_vector_low, .stop_exec, .internal_reset, .break_state,
	.rst_test_high_voltage, .system_reset, .illegal_op_reset, .rst_pin_out, .rst_pin_oe);

// File: dv/test_runaway_code_watchdog.sv
`timescale 1ns/10ps
module test_runaway_code_watchdog;
	import rcw_pkg::*;
	typedef struct packed {logic w; logic [17:0] a; logic [31:0] d; logic [31:0] r; logic e;} rcw_row_t;
	localparam int DIV = 1;
	logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [7:0]  rv = 8'h5a;
	logic        pready, pslverr, system_reset, illegal_op_reset, rst_pin_out, rst_pin_oe;
	logic        stop_exec = 0, internal_reset = 0, brk = 0, stop_mode = 0, vf = 0;
	logic        mon_tst = 0, mon_blank = 0, irq_tv = 0;
	int          errors = 0, compares = 0, cyc = 0, resets = 0, ills = 0, rst_at = 0, t0;
	rcw_row_t    rows [6] = '{'{0, 18'h0, 0, 0, 0}, '{0, 18'h4, 0, 0, 0}, '{0, 18'h8, 0, 0, 1},
		'{1, 18'h0, 1, 0, 0}, '{0, 18'h0, 0, 1, 0}, '{0, 18'h3fffc, 0, 32'h5a, 0}};
	rcw_top #(.OSC_DIVIDE(DIV)) i_rcw_top (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .reset_vector_low(rv), .stop_exec, .stop_mode,
		.internal_reset, .vector_fetch(vf), .monitor_tst_entry(mon_tst),
		.monitor_blank_entry(mon_blank), .irq_test_high_voltage(irq_tv),
		.rst_test_high_voltage(brk), .break_state(brk),
		.system_reset, .illegal_op_reset, .rst_pin_out, .rst_pin_oe);
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (system_reset === 1'b1) resets <= resets + 1;
		if (system_reset === 1'b1) rst_at <= cyc;
		if (illegal_op_reset === 1'b1) ills <= ills + 1;
	end
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#600000;
		errors++;
		report_and_stop;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1;
		repeat (4096*DIV+8) @(posedge clk);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("rdata", rd, rows[i].r);
			chk("slverr", 32'(er), 32'(rows[i].e));
		end
		$display("table done");
		apb(1, 18'h3fffc, 0);
		t0 = cyc;
		repeat (4000*DIV) @(posedge clk);
		rv <= 8'ha5;
		apb(0, 18'h3fffc, 0);
		chk("svc read", rd, 32'ha5);
		while (resets == 0 && cyc < t0 + 10000*DIV) @(posedge clk);
		chk("timeout", 32'(rst_at - t0 >= 8176*DIV-4 && rst_at - t0 <= 8192*DIV+8), 1);
		repeat (32*DIV+10) @(posedge clk);
		apb(0, 18'h4, 0);
		chk("wdog flag", rd, 32'h2);
		apb(1, 18'h4, 32'h2);
		apb(0, 18'h4, 0);
		chk("flag clear", rd, 32'h0);
		$display("timeout test done");
		apb(1, 18'h3fffc, 0);
		repeat (4500*DIV) @(posedge clk);
		apb(1, 18'h3fffc, 32'hff);
		repeat (4500*DIV) @(posedge clk);
		chk("serviced", resets, 1);
		{internal_reset, brk, vf, mon_tst, irq_tv} <= 5'b11111;
		@(posedge clk);
		{vf, mon_tst} <= 2'b00;
		repeat (3) @(posedge clk);
		{internal_reset, brk, irq_tv} <= 3'b000;
		apb(1, 18'h0, 32'h11);
		apb(1, 18'h3fffc, 0);
		repeat (8500*DIV) @(posedge clk);
		chk("disabled", resets, 1);
		$display("service and disable done");
		apb(1, 18'h0, 32'h3);
		stop_exec <= 1;
		@(posedge clk);
		stop_exec <= 0;
		repeat (3) @(posedge clk);
		chk("illegal op", ills, 1);
		apb(0, 18'h4, 0);
		chk("illop flag", rd, 32'h1);
		$display("stop test done");
		apb(1, 18'h0, 32'h1);
		apb(1, 18'h3fffc, 0);
		stop_mode <= 1;
		repeat (8500*DIV) @(posedge clk);
		stop_mode <= 0;
		chk("stop gated", resets, 1);
		mon_blank <= 1;
		@(posedge clk);
		mon_blank <= 0;
		repeat (8500*DIV) @(posedge clk);
		chk("blank monitor", resets, 1);
		$display("stop mode and monitor done");
		arst_n <= 0;
		repeat (2) @(posedge clk);
		chk("reset pin", 32'(rst_pin_oe), 0);
		chk("reset rdata", prdata, 0);
		arst_n <= 1;
		apb(0, 18'h0, 0);
		chk("rate reset", rd, 0);
		$display("mid reset done");
		report_and_stop;
	end
endmodule // test_runaway_code_watchdog

// File: logic/rcw_pkg.sv
package rcw_pkg;

	// Clock and oscillator rates
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned OSC_HZ        = 47_000;
	localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;

	// Counter geometry
	localparam int unsigned PRE_W         = 12;
	localparam int unsigned CNT_W         = 6;
	localparam int unsigned CHAIN_W       = PRE_W + CNT_W;
	localparam int unsigned SHORT_W       = 13;
	localparam int unsigned SVC_LO_BIT    = 4;
	localparam int unsigned PULSE_TICKS   = 32;
	localparam int unsigned POR_TICKS     = 4096;
	localparam int unsigned DIV_W         = 16;

	// APB geometry
	localparam int unsigned ADDR_W        = 18;
	localparam int unsigned IDX_W         = ADDR_W - 2;

	// Register indices (byte address is four times the index)
	localparam logic [IDX_W-1:0] IDX_CONFIG_ONE  = 16'h0000;
	localparam logic [IDX_W-1:0] IDX_RESET_SRC   = 16'h0001;
	localparam logic [IDX_W-1:0] IDX_SERVICE     = 16'hffff;

	// config_register_one fields
	localparam int unsigned CFG_RATE_BIT    = 0;
	localparam int unsigned CFG_STOPDIS_BIT = 1;
	localparam int unsigned CFG_DISABLE_BIT = 4;
	localparam logic [7:0]  CFG_RESET       = 8'h00;

	// reset_source_status fields
	localparam int unsigned RSS_ILLOP_BIT   = 0;
	localparam int unsigned RSS_WDOG_BIT    = 1;
	localparam logic [7:0]  RSS_RESET       = 8'h00;

	function automatic logic [IDX_W-1:0] rcw_index(input logic [ADDR_W-1:0] addr);
		rcw_index = addr[ADDR_W-1:2];
	endfunction

	function automatic logic rcw_mapped(input logic [IDX_W-1:0] idx);
		rcw_mapped = (idx == IDX_CONFIG_ONE) || (idx == IDX_RESET_SRC) || (idx == IDX_SERVICE);
	endfunction

endpackage

// File: logic/rcw_top.sv
// Functional notes
// - 6-bit counter advances on carry of a 12-bit prescaler driven by oscillator ticks.
// - Unserviced overflow raises a system reset after the selected timeout.
// - Rate select 1 gives 2^13-2^4 cycles, 0 gives 2^18-2^4; reset clears it.
// - Any write to service location clears counter and prescaler stages 12..5.
// - Service location reads return reset vector low byte and never clear.
// - Watchdog reset drives reset pin low 32 ticks and sets source flag.
// - Stop instruction clears prescaler; stop mode gates oscillator ticks off unless stop is disabled.
// - Prescaler cleared 4096 oscillator ticks after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears prescaler.
// - Disable bit set blocks watchdog resets; clear means normal operation.
// - No interrupt request output exists; reset is the only action.
// - Monitor entry with test voltage disables while voltage on interrupt or reset pin.
// - Monitor entry by blank vectors disables until next power-on reset.
// - Break state with test voltage on reset pin disables watchdog.
// - Wait mode does not stop counting.
// - Stop disabled by configuration makes stop instruction an illegal opcode reset.
`timescale 1ns/10ps
module rcw_top
	import rcw_pkg::*;
#(
	parameter int unsigned OSC_DIVIDE = OSC_DIV
)(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// System events
	input  wire logic [7:0]        reset_vector_low,
	input  wire logic              stop_exec,
	input  wire logic              stop_mode,
	input  wire logic              internal_reset,
	input  wire logic              vector_fetch,
	// Monitor and break qualifiers
	input  wire logic              monitor_tst_entry,
	input  wire logic              monitor_blank_entry,
	input  wire logic              irq_test_high_voltage,
	input  wire logic              rst_test_high_voltage,
	input  wire logic              break_state,
	// Reset outputs
	output logic                   system_reset,
	output logic                   illegal_op_reset,
	output logic                   rst_pin_out,
	output logic                   rst_pin_oe
);

	typedef struct packed {
		logic [DIV_W-1:0]   div;
		logic [PRE_W-1:0]   pre;
		logic [CNT_W-1:0]   cnt;
		logic [5:0]         pulse;
		logic               pulse_act;
		logic [12:0]        por_cnt;
		logic               por_done;
		logic               rate_sel;
		logic               wd_dis;
		logic               stop_dis;
		logic               flag_wd;
		logic               flag_ill;
		logic               mon_tst;
		logic               mon_blank;
		logic               sysrst;
		logic               illrst;
		logic [31:0]        rdata;
		logic               err;
	} rcw_state_t;

	rcw_state_t s_q;
	rcw_state_t s_d;

	logic               tick;
	logic               osc_tick;
	logic               tick_gate;
	logic               disabled;
	logic               mon_dis;
	logic               brk_dis;
	logic               wr_acc;
	logic               rd_setup;
	logic               wr_cfg;
	logic               wr_rss;
	logic               wr_svc;
	logic               stop_ill;
	logic               stop_clr;
	logic               chain_clr;
	logic               por_hit;
	logic               pulse_end;
	logic [IDX_W-1:0]   idx;
	logic [CHAIN_W-1:0] chain;
	logic [CHAIN_W-1:0] chain_inc;
	logic               hit;
	logic               timeout;
	logic [31:0]        rd_word;

	// Overflow point of the chain for the selected rate
	function automatic logic rcw_chain_hit(
		input logic [CHAIN_W-1:0] chain_v,
		input logic               short_v
	);
		if (short_v)
		begin
			rcw_chain_hit = &chain_v[SHORT_W-1:0];
		end
		else
		begin
			rcw_chain_hit = &chain_v;
		end
	endfunction

	// Read word of a register index
	function automatic logic [31:0] rcw_read_word(
		input logic [IDX_W-1:0] idx_v,
		input logic             rate_v,
		input logic             stopdis_v,
		input logic             wddis_v,
		input logic             flagwd_v,
		input logic             flagill_v,
		input logic [7:0]       vec_v
	);
		rcw_read_word = '0;
		unique case (idx_v)
			IDX_CONFIG_ONE:
			begin
				rcw_read_word[CFG_RATE_BIT]    = rate_v;
				rcw_read_word[CFG_STOPDIS_BIT] = stopdis_v;
				rcw_read_word[CFG_DISABLE_BIT] = wddis_v;
			end
			IDX_RESET_SRC:
			begin
				rcw_read_word[RSS_WDOG_BIT]  = flagwd_v;
				rcw_read_word[RSS_ILLOP_BIT] = flagill_v;
			end
			IDX_SERVICE:
			begin
				rcw_read_word[7:0] = vec_v;
			end
			default:
			begin
				rcw_read_word = '0;
			end
		endcase
	endfunction

	always_comb
	begin
		s_d        = s_q;
		s_d.sysrst = 1'b0;
		s_d.illrst = 1'b0;

		// Bus decode
		idx      = rcw_index(paddr);
		wr_acc   = psel & penable & pwrite;
		rd_setup = psel & ~penable;
		wr_cfg   = wr_acc & (idx == IDX_CONFIG_ONE);
		wr_rss   = wr_acc & (idx == IDX_RESET_SRC);
		wr_svc   = wr_acc & (idx == IDX_SERVICE);
		rd_word  = rcw_read_word(idx, s_q.rate_sel, s_q.stop_dis, s_q.wd_dis, s_q.flag_wd,
			s_q.flag_ill, reset_vector_low);

		// Oscillator tick divider
		tick = (s_q.div == DIV_W'(OSC_DIVIDE - 1));
		if (tick)
		begin
			s_d.div = '0;
		end
		else
		begin
			s_d.div = s_q.div + 1'b1;
		end
		tick_gate = stop_mode & ~s_q.stop_dis;
		osc_tick  = tick & ~tick_gate;

		// Disable qualifiers
		mon_dis  = s_q.mon_tst | s_q.mon_blank;
		brk_dis  = break_state & rst_test_high_voltage;
		disabled = s_q.wd_dis | mon_dis | brk_dis;

		// Stop instruction decode
		stop_ill = stop_exec & s_q.stop_dis;
		stop_clr = stop_exec & ~s_q.stop_dis;

		// Prescaler chain and overflow
		chain     = {s_q.cnt, s_q.pre};
		chain_inc = chain + 1'b1;
		hit       = rcw_chain_hit(chain, s_q.rate_sel);
		timeout   = osc_tick & hit & ~disabled & ~s_q.pulse_act;
		if (osc_tick)
		begin
			s_d.cnt = chain_inc[CHAIN_W-1:PRE_W];
			s_d.pre = chain_inc[PRE_W-1:0];
		end

		// Service write clears counter and upper prescaler stages
		if (wr_svc)
		begin
			s_d.cnt                     = '0;
			s_d.pre[PRE_W-1:SVC_LO_BIT] = '0;
		end

		// Stop instruction
		if (stop_ill)
		begin
			s_d.illrst = 1'b1;
		end
		if (stop_clr)
		begin
			s_d.pre = '0;
		end

		// Reset vector fetch
		if (vector_fetch)
		begin
			s_d.pre = '0;
		end

		// Power-up prescaler clear
		por_hit = ~s_q.por_done & tick & (s_q.por_cnt == 13'(POR_TICKS - 1));
		if (!s_q.por_done && tick)
		begin
			s_d.por_cnt = s_q.por_cnt + 1'b1;
		end
		if (por_hit)
		begin
			s_d.por_done = 1'b1;
			s_d.pre      = '0;
		end

		// Internal resets and disabled state hold the chain cleared
		chain_clr = internal_reset | s_q.pulse_act | timeout | disabled | s_q.illrst;
		if (chain_clr)
		begin
			s_d.cnt = '0;
			s_d.pre = '0;
		end

		// Reset pin pulse
		pulse_end = s_q.pulse_act & tick & (s_q.pulse == 6'(PULSE_TICKS - 1));
		if (s_q.pulse_act && tick)
		begin
			s_d.pulse = s_q.pulse + 1'b1;
		end
		if (pulse_end)
		begin
			s_d.pulse_act = 1'b0;
		end
		if (timeout)
		begin
			s_d.pulse_act = 1'b1;
			s_d.pulse     = '0;
			s_d.sysrst    = 1'b1;
		end

		// Monitor mode latches
		if (!irq_test_high_voltage && !rst_test_high_voltage)
		begin
			s_d.mon_tst = 1'b0;
		end
		if (monitor_tst_entry)
		begin
			s_d.mon_tst = 1'b1;
		end
		if (monitor_blank_entry && !monitor_tst_entry)
		begin
			s_d.mon_blank = 1'b1;
		end

		// Register writes
		if (wr_cfg)
		begin
			s_d.rate_sel = pwdata[CFG_RATE_BIT];
			s_d.stop_dis = pwdata[CFG_STOPDIS_BIT];
			s_d.wd_dis   = pwdata[CFG_DISABLE_BIT];
		end
		if (wr_rss && pwdata[RSS_WDOG_BIT])
		begin
			s_d.flag_wd = 1'b0;
		end
		if (wr_rss && pwdata[RSS_ILLOP_BIT])
		begin
			s_d.flag_ill = 1'b0;
		end

		// Set wins over clear
		if (timeout)
		begin
			s_d.flag_wd = 1'b1;
		end
		if (stop_ill)
		begin
			s_d.flag_ill = 1'b1;
		end

		// Read data and error captured in setup phase
		if (rd_setup)
		begin
			s_d.err   = ~rcw_mapped(idx);
			s_d.rdata = rd_word;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q          <= '0;
			s_q.rate_sel <= CFG_RESET[CFG_RATE_BIT];
			s_q.stop_dis <= CFG_RESET[CFG_STOPDIS_BIT];
			s_q.wd_dis   <= CFG_RESET[CFG_DISABLE_BIT];
			s_q.flag_wd  <= RSS_RESET[RSS_WDOG_BIT];
			s_q.flag_ill <= RSS_RESET[RSS_ILLOP_BIT];
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign pready           = 1'b1;
	assign prdata           = s_q.rdata;
	assign pslverr          = psel & penable & s_q.err;
	assign system_reset     = s_q.sysrst;
	assign illegal_op_reset = s_q.illrst;
	assign rst_pin_out      = 1'b0;
	assign rst_pin_oe       = s_q.pulse_act;

endmodule // rcw_top
